// >>> design/timer2_reload_capture_baud.sv
/*
 timer2_reload_capture_baud: sixteen-bit up timer with auto-reload, capture
 and bit-rate generation for two serial ports, plus its registers and irq.
 Assumes pins are asynchronous, the timer 1 overflow input is a one-cycle
 pulse on CLK, and software uses the strobe register port.
*/
`timescale 1ns/1ps
module timer2_reload_capture_baud
   import timer2_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire timer2_pkg::reg_req_t REQ,
   output logic [7:0] RDATA,
   input wire logic TIMER2_TRIGGER_PIN,
   input wire logic TIMER2_COUNT_PIN,
   input wire logic TIMER1_OVERFLOW,
   output timer2_pkg::bit_clocks_t BIT_CLOCKS,
   output logic TIMER2_OVERFLOW,
   output logic IRQ
);
   typedef struct packed {
      logic [7:0] control;
      logic [7:0] power_control;
      logic [15:0] count;
      logic [15:0] reload;
      logic [1:0] irq_status;
      logic [1:0] irq_enable;
      logic [3:0] prescale;
      logic [3:0] a_tx_div;
      logic [3:0] a_rx_div;
      logic [3:0] b_tx_div;
      logic [3:0] b_rx_div;
      bit_clocks_t clocks;
      logic ovf_pulse;
      logic irq;
      logic [7:0] rdata;
   } state_t;

   state_t state_ff;
   state_t nxt_state;
   logic trig_fall;
   logic count_fall;

   timer2_edge_detect trig_edge (
      .clk(CLK),
      .reset(RESET),
      .pin(TIMER2_TRIGGER_PIN),
      .fall(trig_fall)
   );

   timer2_edge_detect count_edge (
      .clk(CLK),
      .reset(RESET),
      .pin(TIMER2_COUNT_PIN),
      .fall(count_fall)
   );

   logic baud_mode;
   logic run;
   logic exen;
   logic capture_mode;
   logic tick;
   logic overflow;
   logic trig_act;
   logic set_ovf;
   logic set_ext;
   logic t2_a_tx;
   logic t2_a_rx;
   logic t2_b_tx;
   logic t2_b_rx;

   always_comb begin
      nxt_state = state_ff;
      run = state_ff.control[B_RUN];
      exen = state_ff.control[B_EXEN];
      t2_a_tx = state_ff.control[B_TXSRC];
      t2_a_rx = state_ff.control[B_RXSRC];
      t2_b_tx = state_ff.power_control[B_PB_TXSRC];
      t2_b_rx = state_ff.power_control[B_PB_RXSRC];
      // any source bit of either port puts the timer in baud mode
      baud_mode = t2_a_tx | t2_a_rx | t2_b_tx | t2_b_rx;
      capture_mode = state_ff.control[B_CPRL] & ~baud_mode;
      trig_act = exen & trig_fall;

      // tick source
      tick = 1'b0;
      if (!run) begin
         nxt_state.prescale = '0;
      end else if (baud_mode) begin
         // internal clock at half oscillator rate even in counter function
         tick = (state_ff.prescale >= BAUD_LAST);
         nxt_state.prescale = tick ? '0 : state_ff.prescale + 4'h1;
      end else if (state_ff.control[B_CT]) begin
         // each synchronised falling edge counts, up to one per two clocks; nothing holds the pin count below fosc/24
         tick = count_fall;
         nxt_state.prescale = '0;
      end else begin
         tick = (state_ff.prescale >= TIMER_LAST);
         nxt_state.prescale = tick ? '0 : state_ff.prescale + 4'h1;
      end

      overflow = tick & (state_ff.count == COUNT_MAX);
      nxt_state.count = tick ? state_ff.count + 16'h0001 : state_ff.count;

      if (overflow && !capture_mode) begin
         nxt_state.count = state_ff.reload;
      end
      if (trig_act && !baud_mode && !capture_mode) begin
         nxt_state.count = state_ff.reload;
      end
      // capture copies the live count; reload registers stay otherwise
      if (trig_act && capture_mode) begin
         nxt_state.reload = state_ff.count;
      end

      // baud overflow never flags; trigger edge flags in every mode
      set_ovf = overflow & ~baud_mode;
      set_ext = trig_act;
      nxt_state.ovf_pulse = overflow;

      // bit clocks: each direction divides its chosen overflow by 16
      nxt_state.clocks = '0;
      if (t2_a_tx ? overflow : TIMER1_OVERFLOW) begin
         nxt_state.a_tx_div = state_ff.a_tx_div + 4'h1;
         nxt_state.clocks.port_a_tx = (state_ff.a_tx_div == BIT_LAST);
      end
      if (t2_a_rx ? overflow : TIMER1_OVERFLOW) begin
         nxt_state.a_rx_div = state_ff.a_rx_div + 4'h1;
         nxt_state.clocks.port_a_rx = (state_ff.a_rx_div == BIT_LAST);
      end
      if (t2_b_tx ? overflow : TIMER1_OVERFLOW) begin
         nxt_state.b_tx_div = state_ff.b_tx_div + 4'h1;
         nxt_state.clocks.port_b_tx = (state_ff.b_tx_div == BIT_LAST);
      end
      if (t2_b_rx ? overflow : TIMER1_OVERFLOW) begin
         nxt_state.b_rx_div = state_ff.b_rx_div + 4'h1;
         nxt_state.clocks.port_b_rx = (state_ff.b_rx_div == BIT_LAST);
      end

      // register writes; a write to a flag bit is overruled by a set
      if (REQ.wr) begin
         unique case (REQ.addr)
            REG_CONTROL: nxt_state.control = REQ.wdata;
            REG_POWER_CONTROL: nxt_state.power_control = REQ.wdata;
            // writing while running may race a reload; firmware stops first
            REG_COUNT_LOW: nxt_state.count[7:0] = REQ.wdata;
            REG_COUNT_HIGH: nxt_state.count[15:8] = REQ.wdata;
            REG_RELOAD_LOW: nxt_state.reload[7:0] = REQ.wdata;
            REG_RELOAD_HIGH: nxt_state.reload[15:8] = REQ.wdata;
            REG_IRQ_CLEAR: nxt_state.irq_status = state_ff.irq_status & ~REQ.wdata[1:0];
            REG_IRQ_ENABLE: nxt_state.irq_enable = REQ.wdata[1:0];
            default: ;
         endcase
      end
      if (set_ovf) begin
         nxt_state.control[B_OVF] = 1'b1;
         nxt_state.irq_status[I_OVF] = 1'b1;
      end
      if (set_ext) begin
         nxt_state.control[B_EXTF] = 1'b1;
         nxt_state.irq_status[I_EXT] = 1'b1;
      end

      nxt_state.rdata = RESET_BYTE;
      if (REQ.rd) begin
         unique case (REQ.addr)
            REG_CONTROL: nxt_state.rdata = state_ff.control;
            REG_POWER_CONTROL: nxt_state.rdata = state_ff.power_control;
            REG_COUNT_LOW: nxt_state.rdata = state_ff.count[7:0];
            REG_COUNT_HIGH: nxt_state.rdata = state_ff.count[15:8];
            REG_RELOAD_LOW: nxt_state.rdata = state_ff.reload[7:0];
            REG_RELOAD_HIGH: nxt_state.rdata = state_ff.reload[15:8];
            REG_IRQ_STATUS: nxt_state.rdata = {6'h00, state_ff.irq_status};
            REG_IRQ_ENABLE: nxt_state.rdata = {6'h00, state_ff.irq_enable};
            default: nxt_state.rdata = RESET_BYTE;
         endcase
      end
      // level irq follows next status and enable, so it stays registered
      nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_enable);
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign RDATA = state_ff.rdata;
   assign BIT_CLOCKS = state_ff.clocks;
   assign TIMER2_OVERFLOW = state_ff.ovf_pulse;
   assign IRQ = state_ff.irq;
endmodule : timer2_reload_capture_baud

// >>> design/timer2_pkg.sv
/*
 timer2_pkg: register indices, control-bit positions, reset values, timing
 counts and carrier structs for the reload/capture/baud timer.
 Assumes a 200 MHz core clock standing in for the oscillator, and a plain
 strobe register port with read data one cycle after the read strobe.
*/
// Functional notes
// - capture mode with trigger enabled: trigger falling edge latches count into reload pair
// - reload mode: reload count on overflow, and on trigger edge if enabled
// - any baud source bit set: ignore capture select, always reload on overflow
// - port b baud source bits in power control act like port a bits
// - auto-reload, trigger off: count up, overflow loads count from reload pair
// - auto-reload, trigger on: falling trigger edge also reloads the count
// - capture mode: count up without reload; trigger edge copies count to pair
// - baud mode counts at half oscillator rate; overflow never sets overflow flag
// - baud mode, trigger enabled: trigger falling edge raises extra interrupt
// - transmit bit rate from timer 1 when tx source 0, this timer when 1
// - receive source bit picks timer 1 or this timer for receive rate
// - one port may receive from timer 1 while transmitting from this timer
// - baud mode: high byte rollover reloads both count bytes; firmware presets pair
// - modes 1 and 3 bit rate is this timer's overflow rate divided by 16
// - baud mode trigger edge sets external flag without reloading count
package timer2_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_COUNT_LOW = 4'h1;
   localparam logic [ADDR_W-1:0] REG_COUNT_HIGH = 4'h2;
   localparam logic [ADDR_W-1:0] REG_RELOAD_LOW = 4'h3;
   localparam logic [ADDR_W-1:0] REG_RELOAD_HIGH = 4'h4;
   localparam logic [ADDR_W-1:0] REG_POWER_CONTROL = 4'h5;
   localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h6;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 4'h7;
   localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 4'h8;
   // control bit positions
   localparam int B_OVF = 7;
   localparam int B_EXTF = 6;
   localparam int B_RXSRC = 5;
   localparam int B_TXSRC = 4;
   localparam int B_EXEN = 3;
   localparam int B_RUN = 2;
   localparam int B_CT = 1;
   localparam int B_CPRL = 0;
   // power control bits for port b
   localparam int B_PB_RXSRC = 5;
   localparam int B_PB_TXSRC = 4;
   // irq status bits
   localparam int I_OVF = 0;
   localparam int I_EXT = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   // oscillator periods per tick, and timer overflows per bit clock
   localparam int TIMER_DIV = 12;
   localparam int BAUD_DIV = 2;
   localparam int OVF_PER_BIT = 16;
   localparam logic [3:0] TIMER_LAST = 4'(TIMER_DIV - 1);
   localparam logic [3:0] BAUD_LAST = 4'(BAUD_DIV - 1);
   localparam logic [3:0] BIT_LAST = 4'(OVF_PER_BIT - 1);

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic port_a_tx;
      logic port_a_rx;
      logic port_b_tx;
      logic port_b_rx;
   } bit_clocks_t;
endpackage : timer2_pkg

// >>> design/timer2_edge_detect.sv
/*
 timer2_edge_detect: two-flop synchroniser for an external pin plus a
 falling-edge pulse. Assumes the pin is asynchronous to CLK.
*/
`timescale 1ns/1ps
module timer2_edge_detect (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin,
   output logic fall
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } edge_state_t;
   edge_state_t state_ff;
   edge_state_t nxt_state;

   // meta feeds only sync; edge compares two settled samples
   always_comb begin
      nxt_state.meta = pin;
      nxt_state.sync = state_ff.meta;
      nxt_state.last = state_ff.sync;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= '1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign fall = state_ff.last & ~state_ff.sync;
endmodule : timer2_edge_detect

// >>> tb/timer2_reload_capture_baud_monitor.sv
/* checker for the reload/capture/baud timer ports.
   assumes bind to the top; mode bits are tracked from bus writes. */
`timescale 1ns/1ps
module timer2_reload_capture_baud_monitor
   import timer2_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire timer2_pkg::reg_req_t REQ,
   input wire timer2_pkg::bit_clocks_t BIT_CLOCKS,
   input wire logic TIMER1_OVERFLOW,
   input wire logic TIMER2_OVERFLOW,
   input wire logic IRQ
);
   logic [7:0] ctl_ff;
   logic [7:0] pwr_ff;
   // history skips pulses already in flight when a source bit flips
   logic [2:0] txa_ff;
   logic [2:0] rxb_ff;
   logic [2:0] run_ff;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   always_ff @(posedge CLK) begin
      ctl_ff <= RESET ? 8'h00 : (REQ.wr && REQ.addr == REG_CONTROL) ? REQ.wdata : ctl_ff;
      pwr_ff <= RESET ? 8'h00 : (REQ.wr && REQ.addr == REG_POWER_CONTROL) ? REQ.wdata : pwr_ff;
      txa_ff <= RESET ? 3'h0 : {txa_ff[1:0], ctl_ff[B_TXSRC]};
      rxb_ff <= RESET ? 3'h0 : {rxb_ff[1:0], pwr_ff[B_PB_RXSRC]};
      run_ff <= RESET ? 3'h0 : {run_ff[1:0], ctl_ff[B_RUN]};
   end
   a_ovf_one_cycle: assert property (TIMER2_OVERFLOW |=> !TIMER2_OVERFLOW)
      else $error("overflow pulse too long");
   a_txa_one_cycle: assert property (BIT_CLOCKS.port_a_tx |=> !BIT_CLOCKS.port_a_tx)
      else $error("bit clock too long");
   a_txa_from_t1: assert property (
      BIT_CLOCKS.port_a_tx && !ctl_ff[B_TXSRC] && txa_ff == 3'h0
      |-> $past(TIMER1_OVERFLOW) || $past(TIMER1_OVERFLOW, 2)) else $error("tx a not timer 1");
   a_txa_from_t2: assert property (
      BIT_CLOCKS.port_a_tx && ctl_ff[B_TXSRC] && txa_ff == 3'h7
      |-> TIMER2_OVERFLOW || $past(TIMER2_OVERFLOW)) else $error("tx a not timer 2");
   a_rxb_from_t1: assert property (
      BIT_CLOCKS.port_b_rx && !pwr_ff[B_PB_RXSRC] && rxb_ff == 3'h0
      |-> $past(TIMER1_OVERFLOW) || $past(TIMER1_OVERFLOW, 2)) else $error("rx b not timer 1");
   a_rxb_from_t2: assert property (
      BIT_CLOCKS.port_b_rx && pwr_ff[B_PB_RXSRC] && rxb_ff == 3'h7
      |-> TIMER2_OVERFLOW || $past(TIMER2_OVERFLOW)) else $error("rx b not timer 2");
   a_irq_mask_drop: assert property (
      REQ.wr && REQ.addr == REG_IRQ_ENABLE && REQ.wdata == 8'h00 |-> ##2 !IRQ)
      else $error("irq stays up when masked");
   a_stop_no_ovf: assert property (
      run_ff == 3'h0 && !ctl_ff[B_RUN] |-> !TIMER2_OVERFLOW) else $error("stopped timer overflowed");
endmodule : timer2_reload_capture_baud_monitor

// >>> tb/serial_rate_partner.sv
/* serial port rate logic: makes timer 1 overflows, counts bit clocks.
   assumes the timer's clock; counts restart at reset. */
`timescale 1ns/1ps
module serial_rate_partner
   import timer2_pkg::*;
#(parameter int PERIOD = 5)
(
   input wire logic clk,
   input wire logic reset,
   input wire timer2_pkg::bit_clocks_t bit_clocks,
   output logic timer1_overflow,
   output logic [3:0][15:0] pulses
);
   logic [7:0] div_ff;
   always_ff @(posedge clk) begin
      div_ff <= (reset || div_ff == 8'(PERIOD - 1)) ? 8'h00 : div_ff + 8'h01;
      timer1_overflow <= !reset && div_ff == 8'(PERIOD - 1);
      for (int i = 0; i < 4; i++) begin
         pulses[i] <= reset ? 16'h0000 : pulses[i] + 16'(bit_clocks[i]);
      end
   end
endmodule : serial_rate_partner

// >>> tb/timer2_reload_capture_baud_test.sv
/* bench: register-port tests of the reload/capture/baud timer.
   assumes the partner drives timer 1 overflows every 5 clocks. */
`timescale 1ns/1ps
module timer2_reload_capture_baud_test;
   import timer2_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   reg_req_t req = '0;
   logic trig = 1'b1;
   logic cnt_pin = 1'b1;
   logic t1_ovf;
   logic [7:0] rdata;
   bit_clocks_t bclk;
   logic t2_ovf;
   logic irq;
   logic irq_at;
   logic [3:0][15:0] pulses;
   logic [3:0][15:0] p0;
   logic [3:0][15:0] p1;
   int errors = 0;
   int n_tests = 0;
   int k;
   always #2.5 clk = ~clk;
   timer2_reload_capture_baud dut (.CLK(clk), .RESET(reset), .REQ(req), .RDATA(rdata),
      .TIMER2_TRIGGER_PIN(trig), .TIMER2_COUNT_PIN(cnt_pin), .TIMER1_OVERFLOW(t1_ovf),
      .BIT_CLOCKS(bclk), .TIMER2_OVERFLOW(t2_ovf), .IRQ(irq));
   serial_rate_partner #(.PERIOD(5)) far (.clk(clk), .reset(reset), .bit_clocks(bclk),
      .timer1_overflow(t1_ovf), .pulses(pulses));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      irq_at = irq;
      chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata});
      @(posedge clk);
   endtask : rd
   task automatic nap(input int n);
      req <= '0;
      repeat (n) @(posedge clk);
   endtask : nap
   task automatic fall_trig;
      trig <= 1'b0;
      nap(8);
      trig <= 1'b1;
      nap(8);
   endtask : fall_trig
   // one bit clock per 16 overflows; window phase allows one either way
   task automatic rate(input int i, input int mid);
      chk($sformatf("bit clocks lane %0d", i), 16'h0001,
         16'(p1[i] - p0[i] >= mid - 1 && p1[i] - p0[i] <= mid + 1));
   endtask : rate
   // settle after a source change, then count bit clocks over 640 cycles
   task automatic measure;
      nap(40);
      @(negedge clk);
      p0 = pulses;
      repeat (640) @(negedge clk);
      p1 = pulses;
      @(posedge clk);
   endtask : measure
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out;
   end
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      wr(REG_RELOAD_LOW, 8'h34);
      wr(REG_RELOAD_HIGH, 8'h12);
      wr(4'h9, 8'hFF);
      rd(REG_RELOAD_HIGH, 8'h12);
      rd(4'h9, 8'h00);
      rd(REG_IRQ_CLEAR, 8'h00);
      $display("test registers done");
      wr(REG_COUNT_LOW, 8'hFE);
      wr(REG_COUNT_HIGH, 8'hFF);
      wr(REG_RELOAD_LOW, 8'hFC);
      wr(REG_RELOAD_HIGH, 8'hFF);
      wr(REG_IRQ_ENABLE, 8'h01);
      wr(REG_CONTROL, 8'h04);
      req <= '0;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (t2_ovf !== 1'b1 && k < 400);
      chk("cycles to overflow", 16'h0001, 16'(k >= 20 && k <= 30));
      @(posedge clk);
      rd(REG_COUNT_LOW, 8'hFC);
      rd(REG_COUNT_HIGH, 8'hFF);
      rd(REG_CONTROL, 8'h84);
      chk("irq", 16'h0001, {15'h0000, irq_at});
      wr(REG_CONTROL, 8'h00);
      // mask first while status is still set, so the level must drop
      wr(REG_IRQ_ENABLE, 8'h00);
      rd(REG_IRQ_STATUS, 8'h01);
      chk("irq masked", 16'h0000, {15'h0000, irq_at});
      wr(REG_IRQ_CLEAR, 8'h01);
      nap(3);
      rd(REG_IRQ_STATUS, 8'h00);
      chk("irq", 16'h0000, {15'h0000, irq_at});
      $display("test reload done");
      wr(REG_COUNT_LOW, 8'h34);
      wr(REG_COUNT_HIGH, 8'h12);
      wr(REG_IRQ_ENABLE, 8'h02);
      wr(REG_CONTROL, 8'h0F);
      fall_trig;
      rd(REG_RELOAD_LOW, 8'h34);
      rd(REG_CONTROL, 8'h4F);
      repeat (3) begin
         cnt_pin <= 1'b0;
         nap(12);
         cnt_pin <= 1'b1;
         nap(12);
      end
      rd(REG_COUNT_LOW, 8'h37);
      wr(REG_CONTROL, 8'h0E);
      fall_trig;
      rd(REG_COUNT_LOW, 8'h34);
      rd(REG_COUNT_HIGH, 8'h12);
      wr(REG_CONTROL, 8'h00);
      wr(REG_IRQ_CLEAR, 8'h03);
      wr(REG_IRQ_ENABLE, 8'h00);
      $display("test capture done");
      wr(REG_RELOAD_LOW, 8'hFE);
      wr(REG_RELOAD_HIGH, 8'hFF);
      wr(REG_COUNT_LOW, 8'hFE);
      wr(REG_COUNT_HIGH, 8'hFF);
      wr(REG_POWER_CONTROL, 8'h20);
      wr(REG_IRQ_ENABLE, 8'h03);
      wr(REG_CONTROL, 8'h1D);
      measure;
      rate(3, 10);
      rate(0, 10);
      rate(2, 8);
      rate(1, 8);
      rd(REG_IRQ_STATUS, 8'h00);
      fall_trig;
      rd(REG_IRQ_STATUS, 8'h02);
      rd(REG_CONTROL, 8'h5D);
      // the reverse split: port a receives from this timer and transmits from timer 1, port b the opposite
      wr(REG_POWER_CONTROL, 8'h10);
      wr(REG_CONTROL, 8'h2D);
      measure;
      rate(3, 8);
      rate(2, 10);
      rate(1, 10);
      rate(0, 8);
      // stopped but still in baud mode: count is safe to touch
      wr(REG_CONTROL, 8'h28);
      nap(8);
      rd(REG_COUNT_HIGH, 8'hFF);
      wr(REG_COUNT_LOW, 8'h55);
      fall_trig;
      rd(REG_COUNT_LOW, 8'h55);
      $display("test baud done");
      close_out;
   end
endmodule : timer2_reload_capture_baud_test
bind timer2_reload_capture_baud timer2_reload_capture_baud_monitor mon (.CLK(CLK),
   .RESET(RESET), .REQ(REQ), .BIT_CLOCKS(BIT_CLOCKS), .TIMER1_OVERFLOW(TIMER1_OVERFLOW),
   .TIMER2_OVERFLOW(TIMER2_OVERFLOW), .IRQ(IRQ));
